// *** design/sacc_consts.vh ***
// Constants of the SAR converter control block: register addresses,
// field positions, reset values and sequencing counts.
// Assumes an 8-bit special-function register bus with 8-bit addresses.
`ifndef SACC_CONSTS_VH
`define SACC_CONSTS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define SACC_ADDR_CONFIG     8'hBC
`define SACC_ADDR_RES_LOW    8'hBE
`define SACC_ADDR_RES_HIGH   8'hBF
`define SACC_ADDR_HV_CTRL    8'hD6
`define SACC_ADDR_CONTROL    8'hE8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SACC_RST_CONFIG      8'hF8
`define SACC_RST_RESULT      8'h00
`define SACC_RST_HV_CTRL     8'h00
`define SACC_RST_CONTROL     8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SACC_CFG_DIV_HI      7
`define SACC_CFG_DIV_LO      3
`define SACC_CFG_GAIN_HI     2
`define SACC_CFG_GAIN_LO     0
`define SACC_CTL_EN          7
`define SACC_CTL_TM          6
`define SACC_CTL_DONE        5
`define SACC_CTL_BUSY        4
`define SACC_CTL_SRC_HI      3
`define SACC_CTL_SRC_LO      2
`define SACC_CTL_WIN         1
`define SACC_CTL_LJST        0
`define SACC_HV_EN           7
`define SACC_HV_GAIN_HI      3
`define SACC_HV_GAIN_LO      0

// ----------------------------------------------------------------
// Start sources and sequencing counts (in SAR clocks)
// ----------------------------------------------------------------
`define SACC_SRC_SW          2'h0
`define SACC_SRC_T3          2'h1
`define SACC_SRC_EXT         2'h2
`define SACC_SRC_T2          2'h3
`define SACC_TRACK_SAR_CLKS  5'h03
`define SACC_CONV_SAR_CLKS   5'h10

`endif

// *** design/sacc_sar_clk_div.v ***
// SAR clock divider: one-cycle enable pulse every (divide + 1) clocks.
// Assumes the divide value is stable while the divider runs.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Divider
// ----------------------------------------------------------------
module sacc_sar_clk_div (
   input  wire       clk_sys,
   input  wire       sys_rst,
   input  wire       run,
   input  wire [4:0] divide,
   output reg        sar_tick
);

   reg [4:0] count;

   // Counter restarts when idle so every sequence sees a full first period
   always @(posedge clk_sys) begin
      if (sys_rst || !run) begin
         count    <= 5'h00;
         sar_tick <= 1'b0;
      end else if (count == divide) begin
         count    <= 5'h00;
         sar_tick <= 1'b1;
      end else begin
         count    <= count + 5'h01;
         sar_tick <= 1'b0;
      end
   end

endmodule

// *** design/sacc_conv_ctrl.v ***
// Control logic of a 12-bit SAR converter: registers, start selection,
// tracking sequencer, result justification and window flag.
// Assumes the core's register bus, timer overflow pulses and the SAR
// result all run on clk_sys; only the external start pin is asynchronous.
`timescale 1ns/1ps
`include "sacc_consts.vh"

// How it works
// - SAR clock equals system clock divided by divider field plus one.
// - Start source field picks software, timer 3, external edge or timer 2.
// - Busy stays high through conversion; its fall on completion sets the done flag, but a disable abort does not set done.
// - Done flag is only cleared by a software write of zero.
// - Writing one to busy starts only with source 00; zero does nothing.
// - Low-power mode tracks three SAR clocks after the start, then converts.
// - Low-power external mode tracks while pin low, converts on rising edge.
// - Track mode zero tracks continuously whenever enabled and not converting.
// - Enable bit zero shuts the converter down; one makes it ready.
// - Amplifier gain field decodes to 1, 2, 4, 8, 16 or 0.5.
// - High-voltage amplifier enable bit seven; bits six to four reserved.
// - Four-bit high-voltage gain code selects one of sixteen gains.
// - Control bit zero chooses right or left result justification.
// - Right justified: high byte sign-extends bit three, low byte lower eight.
// - Left justified: high byte top eight bits, low nibble reads zero.
// - Window flag is set on a match and held until software clears it.
// - Conversion lasts sixteen SAR clocks before busy falls and results update.
// - Each result is compared against greater-than and less-than limits.
module sacc_conv_ctrl (
   input  wire        clk_sys,
   input  wire        sys_rst,
   input  wire [7:0]  sfr_addr,
   input  wire        sfr_wr,
   input  wire [7:0]  sfr_wdata,
   input  wire        sfr_rd,
   output reg  [7:0]  sfr_rdata,
   input  wire        timer3_overflow,
   input  wire        timer2_overflow,
   input  wire        external_convert_start,
   input  wire [11:0] sar_result,
   input  wire [15:0] window_gt_limit,
   input  wire [15:0] window_lt_limit,
   output reg         converter_powered,
   output reg         track_active,
   output reg         convert_active,
   output wire        sar_clk_en,
   output reg  [2:0]  pga_gain_code,
   output reg         hv_amp_enable,
   output reg  [3:0]  hv_amp_gain_code,
   output reg         conversion_done_flag,
   output reg         window_match_flag
);

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_TRACK = 2'h1;
   localparam [1:0] ST_CONV  = 2'h2;
   // Full reset word, sliced below so no reset assignment loses bits
   localparam [7:0] RST_CONFIG = `SACC_RST_CONFIG;

   // ----------------------------------------------------------------
   // Registers and internal signals
   // ----------------------------------------------------------------
   reg  [4:0]  sar_clock_divider;
   reg  [2:0]  amplifier_gain_select;
   reg         converter_enable;
   reg         track_mode_select;
   reg  [1:0]  start_source_select;
   reg         left_justify_select;
   reg  [7:0]  result_high_byte;
   reg  [7:0]  result_low_byte;
   reg  [1:0]  state;
   reg  [1:0]  next_state;
   reg  [4:0]  sar_count;
   reg         ext_sync1;
   reg         ext_sync2;
   reg         ext_prev;
   reg         start_event;
   reg         next_hi_valid;
   reg  [7:0]  next_result_high;
   reg  [7:0]  next_result_low;
   reg         next_window_hit;
   reg  [2:0]  next_pga_code;
   wire        sar_tick;
   wire        ext_rise;
   wire        conv_busy;
   wire        conv_finish;
   wire        wr_control;
   wire        wr_config;
   wire        wr_hv;
   wire        sw_start;
   wire [15:0] justified_word;

   assign sar_clk_en = sar_tick;
   assign conv_busy  = (state != ST_IDLE);
   assign wr_control = sfr_wr && (sfr_addr == `SACC_ADDR_CONTROL);
   assign wr_config  = sfr_wr && (sfr_addr == `SACC_ADDR_CONFIG);
   assign wr_hv      = sfr_wr && (sfr_addr == `SACC_ADDR_HV_CTRL);

   // Byte writes carry the source field too, so the freshly written value
   // decides whether a busy write is a software start
   assign sw_start = wr_control && sfr_wdata[`SACC_CTL_BUSY] &&
                     (sfr_wdata[`SACC_CTL_SRC_HI:`SACC_CTL_SRC_LO] == `SACC_SRC_SW);

   // Last SAR clock of the conversion period
   assign conv_finish = (state == ST_CONV) && sar_tick &&
                        (sar_count == (`SACC_CONV_SAR_CLKS - 5'h01));

   // ----------------------------------------------------------------
   // SAR clock divider
   // ----------------------------------------------------------------
   // Stopped on the finishing edge and on disable, so no stray tick follows
   sacc_sar_clk_div u_div (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .run      (conv_busy && converter_enable && !conv_finish),
      .divide   (sar_clock_divider),
      .sar_tick (sar_tick)
   );

   // ----------------------------------------------------------------
   // External start pin: two-stage synchroniser then edge detect
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         ext_sync1 <= 1'b0;
         ext_sync2 <= 1'b0;
         ext_prev  <= 1'b0;
      end else begin
         ext_sync1 <= external_convert_start;
         ext_sync2 <= ext_sync1;
         ext_prev  <= ext_sync2;
      end
   end

   assign ext_rise = ext_sync2 && !ext_prev;

   // Start source select; timer overflows are already one-cycle pulses
   always @* begin
      case (start_source_select)
         `SACC_SRC_T3:  start_event = timer3_overflow;
         `SACC_SRC_EXT: start_event = ext_rise;
         `SACC_SRC_T2:  start_event = timer2_overflow;
         default:       start_event = 1'b0;
      endcase
      // Software starts follow the source bits of their own write
      start_event = start_event || sw_start;
   end

   // ----------------------------------------------------------------
   // Tracking and conversion sequencer
   // ----------------------------------------------------------------
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            // Starts during a running sequence never reach here
            if (converter_enable && start_event) begin
               if (track_mode_select && (sw_start || start_source_select != `SACC_SRC_EXT))
                  next_state = ST_TRACK;
               else
                  next_state = ST_CONV;
            end
         end
         ST_TRACK: begin
            if (sar_tick && sar_count == (`SACC_TRACK_SAR_CLKS - 5'h01))
               next_state = ST_CONV;
         end
         ST_CONV: begin
            if (conv_finish)
               next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Disabling aborts any sequence so shutdown is immediate
   always @(posedge clk_sys) begin
      if (sys_rst || !converter_enable) begin
         state     <= ST_IDLE;
         sar_count <= 5'h00;
      end else begin
         state <= next_state;
         if (next_state != state)
            sar_count <= 5'h00;
         else if (sar_tick)
            sar_count <= sar_count + 5'h01;
      end
   end

   // ----------------------------------------------------------------
   // Result justification and window comparison
   // ----------------------------------------------------------------
   always @* begin
      if (left_justify_select) begin
         next_result_high = sar_result[11:4];
         next_result_low  = {sar_result[3:0], 4'h0};
      end else begin
         next_result_high = {{4{sar_result[11]}}, sar_result[11:8]};
         next_result_low  = sar_result[7:0];
      end
   end

   assign justified_word = {next_result_high, next_result_low};

   // Limits in order give an inside window, crossed give an outside one
   always @* begin
      next_hi_valid = (window_lt_limit > window_gt_limit);
      if (next_hi_valid)
         next_window_hit = (justified_word > window_gt_limit) &&
                           (justified_word < window_lt_limit);
      else
         next_window_hit = (justified_word > window_gt_limit) ||
                           (justified_word < window_lt_limit);
   end

   // ----------------------------------------------------------------
   // Register writes and hardware-set flags
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         sar_clock_divider     <= RST_CONFIG[`SACC_CFG_DIV_HI:`SACC_CFG_DIV_LO];
         amplifier_gain_select <= RST_CONFIG[`SACC_CFG_GAIN_HI:`SACC_CFG_GAIN_LO];
         converter_enable      <= 1'b0;
         track_mode_select     <= 1'b0;
         start_source_select   <= `SACC_SRC_SW;
         left_justify_select   <= 1'b0;
         conversion_done_flag  <= 1'b0;
         window_match_flag     <= 1'b0;
         result_high_byte      <= `SACC_RST_RESULT;
         result_low_byte       <= `SACC_RST_RESULT;
         hv_amp_enable         <= 1'b0;
         hv_amp_gain_code      <= 4'h0;
      end else begin
         if (wr_config) begin
            sar_clock_divider     <= sfr_wdata[`SACC_CFG_DIV_HI:`SACC_CFG_DIV_LO];
            amplifier_gain_select <= sfr_wdata[`SACC_CFG_GAIN_HI:`SACC_CFG_GAIN_LO];
         end
         if (wr_control) begin
            converter_enable    <= sfr_wdata[`SACC_CTL_EN];
            track_mode_select   <= sfr_wdata[`SACC_CTL_TM];
            start_source_select <= sfr_wdata[`SACC_CTL_SRC_HI:`SACC_CTL_SRC_LO];
            left_justify_select <= sfr_wdata[`SACC_CTL_LJST];
         end
         if (wr_hv) begin
            hv_amp_enable    <= sfr_wdata[`SACC_HV_EN];
            hv_amp_gain_code <= sfr_wdata[`SACC_HV_GAIN_HI:`SACC_HV_GAIN_LO];
         end
         // Completion sets flags; a same-cycle software clear loses
         if (conv_finish)
            conversion_done_flag <= 1'b1;
         else if (wr_control)
            conversion_done_flag <= sfr_wdata[`SACC_CTL_DONE];
         if (conv_finish && next_window_hit)
            window_match_flag <= 1'b1;
         else if (wr_control)
            window_match_flag <= sfr_wdata[`SACC_CTL_WIN];
         // New result wins over a software write in the same cycle
         if (conv_finish) begin
            result_high_byte <= next_result_high;
            result_low_byte  <= next_result_low;
         end else if (sfr_wr && sfr_addr == `SACC_ADDR_RES_HIGH) begin
            result_high_byte <= sfr_wdata;
         end else if (sfr_wr && sfr_addr == `SACC_ADDR_RES_LOW) begin
            result_low_byte  <= sfr_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Amplifier gain decode: 0 x1, 1 x2, 2 x4, 3 x8, 4 and 5 x16, 6 and 7 x0.5
   // ----------------------------------------------------------------
   always @* begin
      case (amplifier_gain_select)
         3'h0:    next_pga_code = 3'h0;
         3'h1:    next_pga_code = 3'h1;
         3'h2:    next_pga_code = 3'h2;
         3'h3:    next_pga_code = 3'h3;
         3'h4,
         3'h5:    next_pga_code = 3'h4;
         default: next_pga_code = 3'h5;
      endcase
   end

   // ----------------------------------------------------------------
   // Analog-facing control outputs, all registered
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         converter_powered <= 1'b0;
         track_active      <= 1'b0;
         convert_active    <= 1'b0;
         pga_gain_code     <= 3'h0;
      end else begin
         converter_powered <= converter_enable;
         pga_gain_code     <= next_pga_code;
         convert_active    <= converter_enable && (next_state == ST_CONV);
         if (!converter_enable)
            track_active <= 1'b0;
         else if (next_state == ST_TRACK)
            track_active <= 1'b1;
         else if (next_state == ST_IDLE && !track_mode_select)
            track_active <= 1'b1;
         else if (next_state == ST_IDLE && start_source_select == `SACC_SRC_EXT)
            track_active <= !ext_sync2;
         else
            track_active <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Register reads: data one cycle after the strobe, zero elsewhere
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         case (sfr_addr)
            `SACC_ADDR_CONFIG:   sfr_rdata <= {sar_clock_divider, amplifier_gain_select};
            `SACC_ADDR_RES_LOW:  sfr_rdata <= result_low_byte;
            `SACC_ADDR_RES_HIGH: sfr_rdata <= result_high_byte;
            `SACC_ADDR_HV_CTRL:  sfr_rdata <= {hv_amp_enable, 3'h0, hv_amp_gain_code};
            `SACC_ADDR_CONTROL:  sfr_rdata <= {converter_enable, track_mode_select,
                                               conversion_done_flag, conv_busy,
                                               start_source_select, window_match_flag,
                                               left_justify_select};
            default:             sfr_rdata <= 8'h00;
         endcase
      end else begin
         sfr_rdata <= 8'h00;
      end
   end

endmodule

// *** tb/sacc_conv_ctrl_props.sv ***
// Checker for the converter control block, bound to its ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module sacc_props (
   input wire       clk_sys,
   input wire       sys_rst,
   input wire [7:0] sfr_addr,
   input wire       sfr_wr,
   input wire [7:0] sfr_wdata,
   input wire       converter_powered,
   input wire       track_active,
   input wire       convert_active,
   input wire       sar_clk_en,
   input wire       conversion_done_flag,
   input wire       window_match_flag
);
   // ----------------------------------------------------------------
   // Shadow of the mode bits, as last written
   // ----------------------------------------------------------------
   reg  [4:0] div_q;
   reg        tm_q;
   reg  [1:0] src_q;
   wire       ctl_wr = sfr_wr && sfr_addr == 8'hE8;

   // Plain copy of software writes; the design itself is not peeked at
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         div_q <= 5'h1F;
         tm_q  <= 1'b0;
         src_q <= 2'h0;
      end else if (ctl_wr) begin
         tm_q  <= sfr_wdata[6];
         src_q <= sfr_wdata[3:2];
      end else if (sfr_wr && sfr_addr == 8'hBC) begin
         div_q <= sfr_wdata[7:3];
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_done_sticky: assert property (conversion_done_flag && !ctl_wr |=> conversion_done_flag)
      else $error("done flag dropped without a write");
   a_win_sticky: assert property (window_match_flag && !ctl_wr |=> window_match_flag)
      else $error("window flag dropped without a write");
   a_done_on_fall: assert property ($fell(convert_active) && converter_powered |-> conversion_done_flag)
      else $error("busy fell without setting done");
   a_end_on_tick: assert property ($fell(convert_active) && converter_powered |-> $past(sar_clk_en))
      else $error("conversion ended off a SAR tick");
   a_off_idle: assert property (!converter_powered |-> !convert_active && !track_active)
      else $error("activity while shut down");
   a_tick_busy: assert property (sar_clk_en |-> convert_active || track_active)
      else $error("SAR tick outside a conversion");
   a_tick_gap: assert property (sar_clk_en && div_q == 5'h02 |=> !sar_clk_en [*2])
      else $error("SAR tick too early for divide by three");
   a_sw_start: assert property (ctl_wr && sfr_wdata[7] && sfr_wdata[4] && sfr_wdata[3:2] == 2'h0
      && !sfr_wdata[6] && !tm_q && converter_powered && !convert_active |=> convert_active)
      else $error("software start not taken");
   a_zero_no_start: assert property (ctl_wr && !sfr_wdata[4] && sfr_wdata[3:2] == 2'h0
      && src_q == 2'h0 && !sfr_wdata[6] && !tm_q |=> !$rose(convert_active))
      else $error("write of zero started a conversion");

   // Main scenarios reached
   c_done: cover property ($rose(conversion_done_flag));
   c_win: cover property ($rose(window_match_flag));
   c_gap: cover property (sar_clk_en && div_q == 5'h02);
endmodule

bind sacc_conv_ctrl sacc_props i_props (.*);

// *** tb/sacc_far_model.sv ***
// Far side: timer overflows, external start pin and the analog result.
// Assumes the bench requests events just after a rising edge.
`timescale 1ns/1ps
module sacc_far_model (
   input  wire        clk_sys,
   input  wire        fire_t3,
   input  wire        fire_t2,
   input  wire        pin_req,
   input  wire [11:0] code_req,
   output reg         timer3_overflow = 1'b0,
   output reg         timer2_overflow = 1'b0,
   output reg         external_convert_start = 1'b0,
   output reg  [11:0] sar_result = 12'h000
);
   // Overflows last one cycle; result held for a whole conversion
   always @(posedge clk_sys) begin
      timer3_overflow        <= fire_t3;
      timer2_overflow        <= fire_t2;
      external_convert_start <= pin_req;
      sar_result             <= code_req;
   end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the converter control block.
// Assumes the block, its checker and the far-side model are compiled first.
`timescale 1ns/1ps
module tb;
   reg         clk_sys = 1'b0;
   reg         sys_rst = 1'b1;
   reg  [7:0]  sfr_addr = 8'h00;
   reg         sfr_wr = 1'b0;
   reg  [7:0]  sfr_wdata = 8'h00;
   reg         sfr_rd = 1'b0;
   reg         fire_t3 = 1'b0;
   reg         fire_t2 = 1'b0;
   reg         pin_req = 1'b0;
   reg  [11:0] code_req = 12'h000;
   reg  [15:0] gt_lim = 16'h0000;
   reg  [15:0] lt_lim = 16'h0000;
   reg         lp = 1'b0;
   reg  [15:0] busy_len = 16'h0000;
   reg  [15:0] tick_cnt = 16'h0000;
   reg  [31:0] rng = 32'h5BF8;
   reg  [7:0]  v;
   wire [7:0]  rdata;
   wire        t3, t2, pin, pwr, trk, cnv, tick, dfl, wfl, hv_en;
   wire [11:0] res;
   wire [2:0]  pga;
   wire [3:0]  hv_g;
   integer     failures = 0;
   integer     comparisons = 0;
   integer     i;
   localparam [47:0] ADRS = 48'hBDE8D6BFBEBC;

   initial forever #2 clk_sys = ~clk_sys;

   sacc_far_model i_far (.clk_sys(clk_sys), .fire_t3(fire_t3), .fire_t2(fire_t2),
      .pin_req(pin_req), .code_req(code_req), .timer3_overflow(t3), .timer2_overflow(t2),
      .external_convert_start(pin), .sar_result(res));
   sacc_conv_ctrl i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(rdata),
      .timer3_overflow(t3), .timer2_overflow(t2), .external_convert_start(pin),
      .sar_result(res), .window_gt_limit(gt_lim), .window_lt_limit(lt_lim),
      .converter_powered(pwr), .track_active(trk), .convert_active(cnv), .sar_clk_en(tick),
      .pga_gain_code(pga), .hv_amp_enable(hv_en), .hv_amp_gain_code(hv_g),
      .conversion_done_flag(dfl), .window_match_flag(wfl));

   // Busy cycles and SAR ticks, free-running; scenarios compare differences
   always @(posedge clk_sys) begin
      if (cnv | (lp & trk)) busy_len <= busy_len + 16'h0001;
      if (tick) tick_cnt <= tick_cnt + 16'h0001;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function [31:0] xs(input [31:0] s);
      reg [31:0] x;
      begin
         x = s ^ (s << 13);
         x = x ^ (x >> 17);
         xs = x ^ (x << 5);
      end
   endfunction

   task cyc(input integer n);
      begin
         repeat (n) @(posedge clk_sys);
         #1;
      end
   endtask

   task chk(input [15:0] seen, input [15:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   task wr(input [7:0] a, input [7:0] d);
      begin
         sfr_addr = a;
         sfr_wdata = d;
         sfr_wr = 1'b1;
         cyc(1);
         sfr_wr = 1'b0;
         cyc(1);
      end
   endtask

   // Read data stands only in the cycle after the strobe
   task rd(input [7:0] a, output [7:0] d);
      begin
         sfr_addr = a;
         sfr_rd = 1'b1;
         cyc(1);
         sfr_rd = 1'b0;
         d = rdata;
         cyc(1);
      end
   endtask

   task wrap_up;
      begin
         if (failures == 0 && comparisons > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   // One conversion: set mode, trigger, poll done, check length and data
   task conv(input [1:0] src, input tm, input lj, input [4:0] dv);
      integer n;
      reg [15:0] w;
      reg [15:0] b0;
      reg [15:0] t0;
      reg [7:0] hi;
      begin
         rng = xs(rng);
         code_req = rng[11:0];
         gt_lim = rng[31:16];
         lt_lim = rng[23:8];
         w = lj ? {code_req, 4'h0} : {{4{code_req[11]}}, code_req};
         lp = tm && src != 2'h2;
         wr(8'hBC, {dv, 3'h0});
         wr(8'hE8, {1'b1, tm, 2'b00, src, 1'b0, lj});
         cyc(4);
         chk(trk, !tm || src == 2'h2);
         b0 = busy_len;
         t0 = tick_cnt;
         case (src)
            2'h0: wr(8'hE8, {1'b1, tm, 2'b01, src, 1'b0, lj});
            2'h1: fire_t3 = 1'b1;
            2'h2: pin_req = 1'b1;
            default: fire_t2 = 1'b1;
         endcase
         n = 0;
         while (dfl !== 1'b1 && n < 1000) begin
            cyc(1);
            fire_t3 = (n == 6); // late starts must be ignored
            fire_t2 = (n == 6);
            n = n + 1;
         end
         if (n >= 1000) begin
            failures = failures + 1;
            wrap_up;
         end
         pin_req = 1'b0;
         cyc(3);
         chk(busy_len - b0, (lp ? 19 : 16) * (dv + 1) + 1);
         chk(tick_cnt - t0, lp ? 19 : 16);
         rd(8'hE8, v);
         chk(v[5:4], 2'b10);
         rd(8'hBF, hi);
         rd(8'hBE, v);
         chk({hi, v}, w);
         chk(wfl, (lt_lim > gt_lim) ? (w > gt_lim && w < lt_lim)
            : (w > gt_lim || w < lt_lim));
      end
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      cyc(20);
      sys_rst = 1'b0;
      // Reset values, unmapped address last
      for (i = 0; i < 6; i = i + 1) begin
         rd(ADRS[8*i +: 8], v);
         chk(v, i == 0 ? 8'hF8 : 8'h00);
      end
      for (i = 0; i < 8; i = i + 1) begin
         wr(8'hBC, {5'h1F, i[2:0]});
         cyc(2);
         chk(pga, i < 4 ? i : (i < 6 ? 4 : 5));
      end
      for (i = 0; i < 4; i = i + 1) begin
         rng = xs(rng);
         wr(8'hD6, rng[7:0]);
         cyc(2);
         chk({hv_en, hv_g}, {rng[7], rng[3:0]});
         rd(8'hD6, v);
         chk(v, {rng[7], 3'h0, rng[3:0]});
      end
      // Every source in both tracking modes, then random mixes
      conv(2'h0, 1'b0, 1'b0, 5'h02);
      conv(2'h2, 1'b1, 1'b1, 5'h1F);
      for (i = 0; i < 8; i = i + 1)
         conv(i[1:0], i[2], i[0], i[1:0]);
      for (i = 0; i < 16; i = i + 1) begin
         rng = xs(rng);
         conv(rng[1:0], rng[2], rng[3], rng[6:4]);
      end
      // Shut down: a timer overflow must not start anything
      wr(8'hE8, 8'h04);
      fire_t3 = 1'b1;
      cyc(1);
      fire_t3 = 1'b0;
      cyc(40);
      chk({pwr, cnv, trk, dfl}, 4'h0);
      wrap_up;
   end
endmodule
